// ---- tmr_pkg.sv ----
/*
  Constants, types and register map of the 16-bit timer waveform
  controller. Assumes an APB master with 32-bit data and 8-bit addresses.
*/
// Operation
// - Everything runs on sys_clk; counting, flags and buffered loads happen on tick cycles.
// - Loads and overflow at BOTTOM follow the same timing as at TOP.
// - A nonzero channel output mode hands the pin to the waveform, except refused toggle codes and mode 13.
// - The pin is driven only while its direction bit selects output.
// - Non-PWM codes: off, toggle, clear or set on compare match.
// - Fast PWM: code 10 clears on match, sets at TOP; 11 reverses.
// - Fast PWM code 01 toggles channel A in modes 14, 15 only.
// - Fast PWM ignores a match at TOP when the upper code bit is set.
// - Dual-slope: code 10 clears upcounting, sets downcounting; 11 reverses.
// - Dual-slope code 01 toggles channel A in modes 8 to 11 only.
// - Mode is two low bits of control A, two high of B.
// - Modes 1-3 and 5-7 use fixed TOPs, load at TOP.
// - Modes 0, 4, 12 load compares at once; overflow at MAX.
// - Modes 8, 9 are dual-slope, loading and flagging at BOTTOM.
// - Modes 10, 11 dual load at TOP; 14, 15 fast; 13 reserved.
// - Control A bits 3 and 2 always read zero.
// - Dual-slope reverses at TOP and BOTTOM without holding either for an extra tick.
package tmr_pkg;
  localparam logic [7:0] OFF_CTRL_A = 8'h00;
  localparam logic [7:0] OFF_CTRL_B = 8'h04;
  localparam logic [7:0] OFF_COUNT = 8'h08;
  localparam logic [7:0] OFF_CMP_A = 8'h0C;
  localparam logic [7:0] OFF_CMP_B = 8'h10;
  localparam logic [7:0] OFF_CAPT = 8'h14;
  localparam logic [7:0] OFF_IRQ_ST = 8'h18;
  localparam logic [7:0] OFF_IRQ_MSK = 8'h1C;
  localparam logic [7:0] OFF_PIN = 8'h20;
  localparam int CA_OM_A = 6;
  localparam int CA_OM_B = 4;
  localparam int CB_WM_HI = 3;
  localparam int PIN_DIR_A = 0;
  localparam int PIN_DIR_B = 1;
  localparam int PIN_DAT_A = 4;
  localparam int PIN_DAT_B = 5;
  localparam int IRQ_OVF = 0;
  localparam int IRQ_CMPA = 1;
  localparam int IRQ_CMPB = 2;
  localparam logic [7:0] CTRL_A_WMASK = 8'hF3;
  localparam logic [7:0] CTRL_B_WMASK = 8'h18;
  localparam logic [7:0] PIN_WMASK = 8'h33;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [15:0] TOP_8B = 16'h00FF;
  localparam logic [15:0] TOP_9B = 16'h01FF;
  localparam logic [15:0] TOP_10B = 16'h03FF;
  localparam logic [15:0] TOP_MAX = 16'hFFFF;
  localparam logic [15:0] BOTTOM = 16'h0000;
  localparam logic [1:0] OM_OFF = 2'h0;
  localparam logic [1:0] OM_TOGGLE = 2'h1;
  localparam logic [1:0] OM_CLEAR = 2'h2;
  localparam logic [1:0] OM_SET = 2'h3;
  localparam logic [3:0] WM_FAST_TGL = 4'hE;
  localparam logic [3:0] WM_DUAL_TGL_LO = 4'h8;
  localparam logic [3:0] WM_DUAL_TGL_HI = 4'hB;

  typedef enum logic [2:0] {CLS_NORMAL, CLS_CTC, CLS_FAST, CLS_DUAL, CLS_RSVD} tmr_cls_t;
  typedef enum logic [1:0] {TOP_FIXED, TOP_CMPA, TOP_CAPT} tmr_topsrc_t;
  typedef enum logic [1:0] {AT_NOW, AT_TOP, AT_BOTTOM, AT_MAX} tmr_point_t;

  typedef struct packed {
    tmr_cls_t cls;
    tmr_topsrc_t topSrc;
    logic [15:0] fixedTop;
    tmr_point_t loadAt;
    tmr_point_t tovAt;
  } tmr_cfg_t;

  typedef struct packed {
    logic match;
    logic atTop;
    logic countUp;
  } tmr_evt_t;
endpackage

// ---- tmr_mode_dec.sv ----
/*
  Decodes the 4-bit waveform mode into counting class, TOP source,
  compare load point and overflow point. Purely combinational.
*/
`timescale 1ns/1ps
`default_nettype none
module tmr_mode_dec (
  input wire logic [3:0] waveModeSel,
  output tmr_pkg::tmr_cfg_t cfg
);
  always_comb begin
    cfg.cls = tmr_pkg::CLS_NORMAL;
    cfg.topSrc = tmr_pkg::TOP_FIXED;
    cfg.fixedTop = tmr_pkg::TOP_MAX;
    cfg.loadAt = tmr_pkg::AT_NOW;
    cfg.tovAt = tmr_pkg::AT_MAX;
    unique case (waveModeSel)
      4'h0: cfg.cls = tmr_pkg::CLS_NORMAL;
      4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7: begin
        cfg.cls = waveModeSel[2] ? tmr_pkg::CLS_FAST : tmr_pkg::CLS_DUAL;
        cfg.fixedTop = (waveModeSel[1:0] == 2'h1) ? tmr_pkg::TOP_8B :
                       (waveModeSel[1:0] == 2'h2) ? tmr_pkg::TOP_9B : tmr_pkg::TOP_10B;
        cfg.loadAt = tmr_pkg::AT_TOP;
        cfg.tovAt = waveModeSel[2] ? tmr_pkg::AT_TOP : tmr_pkg::AT_BOTTOM;
      end
      4'h4, 4'hC: begin
        cfg.cls = tmr_pkg::CLS_CTC;
        cfg.topSrc = waveModeSel[3] ? tmr_pkg::TOP_CAPT : tmr_pkg::TOP_CMPA;
      end
      4'h8, 4'h9, 4'hA, 4'hB: begin
        cfg.cls = tmr_pkg::CLS_DUAL;
        cfg.topSrc = waveModeSel[0] ? tmr_pkg::TOP_CMPA : tmr_pkg::TOP_CAPT;
        cfg.loadAt = waveModeSel[1] ? tmr_pkg::AT_TOP : tmr_pkg::AT_BOTTOM;
        cfg.tovAt = tmr_pkg::AT_BOTTOM;
      end
      4'hD: cfg.cls = tmr_pkg::CLS_RSVD;
      4'hE, 4'hF: begin
        cfg.cls = tmr_pkg::CLS_FAST;
        cfg.topSrc = waveModeSel[0] ? tmr_pkg::TOP_CMPA : tmr_pkg::TOP_CAPT;
        cfg.loadAt = tmr_pkg::AT_TOP;
        cfg.tovAt = tmr_pkg::AT_TOP;
      end
    endcase
  end
endmodule // tmr_mode_dec
`default_nettype wire

// ---- tmr_out_unit.sv ----
/*
  One compare output channel: waveform flip-flop and pin driver.
  Assumes events arrive already qualified by the timer tick.
*/
`timescale 1ns/1ps
`default_nettype none
module tmr_out_unit (
  input wire logic sys_clk,
  input wire logic rstSyncN,
  input wire logic ce,
  input wire tmr_pkg::tmr_cls_t cls,
  input wire logic [1:0] outMode,
  input wire logic toggleOk,
  input wire tmr_pkg::tmr_evt_t evt,
  input wire logic dirOut,
  input wire logic portData,
  output logic pinOut,
  output logic pinOeN
);
  logic wave_r;
  logic waveNxt;
  logic connected;

  // Unsupported toggle codes fall back to the port
  assign connected = (outMode != tmr_pkg::OM_OFF) && (cls != tmr_pkg::CLS_RSVD) &&
                     ((outMode != tmr_pkg::OM_TOGGLE) || toggleOk);

  always_comb begin
    waveNxt = wave_r;
    unique case (cls)
      tmr_pkg::CLS_NORMAL, tmr_pkg::CLS_CTC: begin
        if (evt.match) begin
          unique case (outMode)
            tmr_pkg::OM_OFF: waveNxt = wave_r;
            tmr_pkg::OM_TOGGLE: waveNxt = ~wave_r;
            tmr_pkg::OM_CLEAR: waveNxt = 1'b0;
            tmr_pkg::OM_SET: waveNxt = 1'b1;
          endcase
        end
      end
      tmr_pkg::CLS_FAST: begin
        if (outMode == tmr_pkg::OM_TOGGLE) begin
          if (evt.match && toggleOk) waveNxt = ~wave_r;
        end else if (outMode[1]) begin
          if (evt.atTop) waveNxt = ~outMode[0];
          else if (evt.match) waveNxt = outMode[0];
        end
      end
      tmr_pkg::CLS_DUAL: begin
        if (outMode == tmr_pkg::OM_TOGGLE) begin
          if (evt.match && toggleOk) waveNxt = ~wave_r;
        end else if (outMode[1] && evt.match) begin
          waveNxt = evt.countUp ? outMode[0] : ~outMode[0];
        end
      end
      tmr_pkg::CLS_RSVD: waveNxt = wave_r;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      wave_r <= 1'b0;
      pinOut <= 1'b0;
      pinOeN <= 1'b1;
    end else if (ce) begin
      wave_r <= waveNxt;
      pinOut <= connected ? wave_r : portData;
      pinOeN <= ~dirOut;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstSyncN);

  pin_oe_a:
    assert property (ce |=> (pinOeN == !$past(dirOut)))
    else $error("pin enable does not follow direction bit");
  port_pass_a:
    assert property ((ce && outMode == tmr_pkg::OM_OFF) |=> (pinOut == $past(portData)))
    else $error("disconnected channel does not pass port data");
  fast_top_set_a:
    assert property ((ce && cls == tmr_pkg::CLS_FAST && outMode == tmr_pkg::OM_CLEAR &&
                      evt.atTop) |=> wave_r)
    else $error("fast mode code 10 did not set at TOP");
  dual_up_clear_a:
    assert property ((ce && cls == tmr_pkg::CLS_DUAL && outMode == tmr_pkg::OM_CLEAR &&
                      evt.match && evt.countUp) |=> !wave_r)
    else $error("dual mode code 10 did not clear on upcount match");
  normal_toggle_a:
    assert property ((ce && cls == tmr_pkg::CLS_NORMAL && outMode == tmr_pkg::OM_TOGGLE &&
                      evt.match) |=> (wave_r != $past(wave_r)))
    else $error("normal mode toggle missed");
endmodule // tmr_out_unit
`default_nettype wire

// ---- tmr_wave_ctrl.sv ----
/*
  16-bit timer with waveform generation modes, two compare channels,
  APB register slave and one level interrupt. Assumes timerTick is a
  one-cycle enable from an external prescaler, synchronous to sys_clk.
*/
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module tmr_wave_ctrl (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic timerTick,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic waveOutA,
  output logic waveOutAOeN,
  output logic waveOutB,
  output logic waveOutBOeN
);
  logic [1:0] rstPipe_r;
  logic rstSyncN;
  logic [7:0] ctrlA_r;
  logic [7:0] ctrlB_r;
  logic [7:0] pinCfg_r;
  logic [15:0] count_r;
  logic [15:0] countNxt;
  logic dir_r;
  logic dirNxt;
  logic [15:0] bufA_r;
  logic [15:0] bufB_r;
  logic [15:0] cmpA_r;
  logic [15:0] cmpB_r;
  logic [15:0] capt_r;
  logic [2:0] irqSt_r;
  logic [2:0] irqMsk_r;
  logic [2:0] events;
  logic blockMatch_r;
  logic [3:0] waveModeSel;
  tmr_pkg::tmr_cfg_t cfg;
  logic [15:0] topVal;
  logic atTop;
  logic atBottom;
  logic atMax;
  logic step;
  logic access;
  logic wrEn;
  logic countWr;
  logic wrCmpA;
  logic wrCmpB;
  logic hitA;
  logic hitB;
  logic loadNow;
  logic tovEvt;
  logic toggleOkA;
  logic toggleOkB;
  logic [31:0] rdData;
  logic mapped;
  tmr_pkg::tmr_evt_t evtA;
  tmr_pkg::tmr_evt_t evtB;

  function automatic logic [15:0] step16(input logic [15:0] v, input logic up);
    step16 = up ? 16'(v + 16'h0001) : 16'(v - 16'h0001);
  endfunction

  function automatic logic pointHit(input tmr_pkg::tmr_point_t p, input logic t,
                                    input logic b, input logic m);
    unique case (p)
      tmr_pkg::AT_NOW: pointHit = 1'b0;
      tmr_pkg::AT_TOP: pointHit = t;
      tmr_pkg::AT_BOTTOM: pointHit = b;
      tmr_pkg::AT_MAX: pointHit = m;
    endcase
  endfunction

  // Reset release through two flops
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) rstPipe_r <= 2'h0;
    else rstPipe_r <= {rstPipe_r[0], 1'b1};
  end
  assign rstSyncN = rstPipe_r[1];

  // APB: one wait state, answer in the second access cycle
  assign access = psel & penable;
  assign wrEn = ce & access & pready & pwrite;
  assign countWr = wrEn && (paddr == tmr_pkg::OFF_COUNT);
  assign wrCmpA = wrEn && (paddr == tmr_pkg::OFF_CMP_A);
  assign wrCmpB = wrEn && (paddr == tmr_pkg::OFF_CMP_B);

  always_comb begin
    rdData = 32'h0000_0000;
    mapped = 1'b1;
    case (paddr)
      tmr_pkg::OFF_CTRL_A: rdData = {24'h00_0000, ctrlA_r};
      tmr_pkg::OFF_CTRL_B: rdData = {24'h00_0000, ctrlB_r};
      tmr_pkg::OFF_COUNT: rdData = {16'h0000, count_r};
      tmr_pkg::OFF_CMP_A: rdData = {16'h0000, bufA_r};
      tmr_pkg::OFF_CMP_B: rdData = {16'h0000, bufB_r};
      tmr_pkg::OFF_CAPT: rdData = {16'h0000, capt_r};
      tmr_pkg::OFF_IRQ_ST: rdData = {29'h0000_0000, irqSt_r};
      tmr_pkg::OFF_IRQ_MSK: rdData = {29'h0000_0000, irqMsk_r};
      tmr_pkg::OFF_PIN: rdData = {24'h00_0000, pinCfg_r};
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (ce) begin
      pready <= access & ~pready;
      pslverr <= access & ~pready & ~mapped;
      if (access && !pready) prdata <= pwrite ? 32'h0000_0000 : rdData;
    end
  end

  // Control and pin registers; masks keep unused bits at zero
  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      ctrlA_r <= tmr_pkg::CTRL_RST;
      ctrlB_r <= tmr_pkg::CTRL_RST;
      pinCfg_r <= tmr_pkg::CTRL_RST;
      capt_r <= 16'h0000;
      irqMsk_r <= 3'h0;
    end else if (wrEn) begin
      case (paddr)
        tmr_pkg::OFF_CTRL_A: ctrlA_r <= pwdata[7:0] & tmr_pkg::CTRL_A_WMASK;
        tmr_pkg::OFF_CTRL_B: ctrlB_r <= pwdata[7:0] & tmr_pkg::CTRL_B_WMASK;
        tmr_pkg::OFF_PIN: pinCfg_r <= pwdata[7:0] & tmr_pkg::PIN_WMASK;
        tmr_pkg::OFF_CAPT: capt_r <= pwdata[15:0];
        tmr_pkg::OFF_IRQ_MSK: irqMsk_r <= pwdata[2:0];
        default: ;
      endcase
    end
  end

  assign waveModeSel = {ctrlB_r[tmr_pkg::CB_WM_HI +: 2], ctrlA_r[1:0]};

  tmr_mode_dec u_dec (
    .waveModeSel(waveModeSel),
    .cfg(cfg)
  );

  always_comb begin
    unique case (cfg.topSrc)
      tmr_pkg::TOP_FIXED: topVal = cfg.fixedTop;
      tmr_pkg::TOP_CMPA: topVal = cmpA_r;
      tmr_pkg::TOP_CAPT: topVal = capt_r;
      default: topVal = tmr_pkg::TOP_MAX;
    endcase
  end

  assign atTop = (count_r == topVal);
  assign atBottom = (count_r == tmr_pkg::BOTTOM);
  assign atMax = (count_r == tmr_pkg::TOP_MAX);
  // Tick is an enable, never a clock
  assign step = ce & timerTick & (cfg.cls != tmr_pkg::CLS_RSVD);

  // Count sequence; TOP below 1 in dual mode is not supported
  always_comb begin
    countNxt = count_r;
    dirNxt = 1'b1;
    unique case (cfg.cls)
      tmr_pkg::CLS_NORMAL: countNxt = step16(count_r, 1'b1);
      tmr_pkg::CLS_CTC, tmr_pkg::CLS_FAST:
        countNxt = atTop ? tmr_pkg::BOTTOM : step16(count_r, 1'b1);
      tmr_pkg::CLS_DUAL: begin
        if (dir_r) begin
          dirNxt = (count_r < topVal);
          countNxt = step16(count_r, dirNxt);
        end else begin
          dirNxt = atBottom;
          countNxt = step16(count_r, dirNxt);
        end
      end
      tmr_pkg::CLS_RSVD: dirNxt = dir_r;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      count_r <= 16'h0000;
      dir_r <= 1'b1;
    end else if (ce) begin
      if (countWr) begin
        count_r <= pwdata[15:0];
      end else if (step) begin
        count_r <= countNxt;
        dir_r <= dirNxt;
      end
    end
  end

  // A counter write hides the match on the next tick
  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) blockMatch_r <= 1'b0;
    else if (ce) begin
      if (countWr) blockMatch_r <= 1'b1;
      else if (step) blockMatch_r <= 1'b0;
    end
  end

  assign hitA = step & ~blockMatch_r & (count_r == cmpA_r);
  assign hitB = step & ~blockMatch_r & (count_r == cmpB_r);
  // BOTTOM points use the same tick timing as TOP points
  assign loadNow = step & pointHit(cfg.loadAt, atTop, atBottom, atMax);
  assign tovEvt = step & pointHit(cfg.tovAt, atTop, atBottom, atMax);

  // Compare buffers; immediate modes write straight through
  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      bufA_r <= 16'h0000;
      bufB_r <= 16'h0000;
      cmpA_r <= 16'h0000;
      cmpB_r <= 16'h0000;
    end else if (ce) begin
      if (wrCmpA) bufA_r <= pwdata[15:0];
      if (wrCmpB) bufB_r <= pwdata[15:0];
      if (cfg.loadAt == tmr_pkg::AT_NOW) begin
        if (wrCmpA) cmpA_r <= pwdata[15:0];
        if (wrCmpB) cmpB_r <= pwdata[15:0];
      end else if (loadNow) begin
        cmpA_r <= bufA_r;
        cmpB_r <= bufB_r;
      end
    end
  end

  // Sticky flags: an event wins over a same-cycle clear
  always_comb begin
    events = 3'h0;
    events[tmr_pkg::IRQ_OVF] = tovEvt;
    events[tmr_pkg::IRQ_CMPA] = hitA;
    events[tmr_pkg::IRQ_CMPB] = hitB;
  end

  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      irqSt_r <= 3'h0;
      irq <= 1'b0;
    end else if (ce) begin
      if (wrEn && paddr == tmr_pkg::OFF_IRQ_ST) irqSt_r <= (irqSt_r & ~pwdata[2:0]) | events;
      else irqSt_r <= irqSt_r | events;
      irq <= |(irqSt_r & irqMsk_r);
    end
  end

  // Toggle support per channel and class
  always_comb begin
    toggleOkA = 1'b0;
    toggleOkB = 1'b0;
    unique case (cfg.cls)
      tmr_pkg::CLS_NORMAL, tmr_pkg::CLS_CTC: begin
        toggleOkA = 1'b1;
        toggleOkB = 1'b1;
      end
      tmr_pkg::CLS_FAST: toggleOkA = (waveModeSel >= tmr_pkg::WM_FAST_TGL);
      tmr_pkg::CLS_DUAL: toggleOkA = (waveModeSel >= tmr_pkg::WM_DUAL_TGL_LO) &&
                                     (waveModeSel <= tmr_pkg::WM_DUAL_TGL_HI);
      tmr_pkg::CLS_RSVD: toggleOkA = 1'b0;
    endcase
  end

  // Fast PWM: compare equal to TOP with set/clear code acts at TOP only
  always_comb begin
    evtA.match = hitA & ~((cfg.cls == tmr_pkg::CLS_FAST) && (cmpA_r == topVal) &&
                          ctrlA_r[tmr_pkg::CA_OM_A + 1]);
    evtB.match = hitB & ~((cfg.cls == tmr_pkg::CLS_FAST) && (cmpB_r == topVal) &&
                          ctrlA_r[tmr_pkg::CA_OM_B + 1]);
    evtA.atTop = step & atTop;
    evtB.atTop = step & atTop;
    evtA.countUp = dir_r;
    evtB.countUp = dir_r;
  end

  tmr_out_unit u_outA (
    .sys_clk(sys_clk),
    .rstSyncN(rstSyncN),
    .ce(ce),
    .cls(cfg.cls),
    .outMode(ctrlA_r[tmr_pkg::CA_OM_A +: 2]),
    .toggleOk(toggleOkA),
    .evt(evtA),
    .dirOut(pinCfg_r[tmr_pkg::PIN_DIR_A]),
    .portData(pinCfg_r[tmr_pkg::PIN_DAT_A]),
    .pinOut(waveOutA),
    .pinOeN(waveOutAOeN)
  );

  tmr_out_unit u_outB (
    .sys_clk(sys_clk),
    .rstSyncN(rstSyncN),
    .ce(ce),
    .cls(cfg.cls),
    .outMode(ctrlA_r[tmr_pkg::CA_OM_B +: 2]),
    .toggleOk(toggleOkB),
    .evt(evtB),
    .dirOut(pinCfg_r[tmr_pkg::PIN_DIR_B]),
    .portData(pinCfg_r[tmr_pkg::PIN_DAT_B]),
    .pinOut(waveOutB),
    .pinOeN(waveOutBOeN)
  );

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstSyncN);

  sequence seqDualTop;
    step && cfg.cls == tmr_pkg::CLS_DUAL && dir_r && atTop && !countWr &&
    topVal > 16'h0001;
  endsequence

  sequence seqDualBottom;
    step && cfg.cls == tmr_pkg::CLS_DUAL && !dir_r && atBottom && !countWr;
  endsequence

  reserved_zero_a:
    assert property ((ce && access && !pready && !pwrite && paddr == tmr_pkg::OFF_CTRL_A)
                     |=> (pready && prdata[3:2] == 2'h0))
    else $error("control A reserved bits read nonzero");
  mode_join_a:
    assert property ((wrEn && paddr == tmr_pkg::OFF_CTRL_B)
                     |=> (waveModeSel[3:2] == $past(pwdata[4:3])))
    else $error("mode high bits not taken from control B");
  tick_only_a:
    assert property ((ce && !timerTick && !countWr) |=> $stable(count_r))
    else $error("counter moved without a tick");
  dual_top_a:
    assert property (seqDualTop |=> (!dir_r && count_r == 16'($past(topVal) - 16'h0001)))
    else $error("dual slope did not turn at TOP");
  dual_bottom_a:
    assert property (seqDualBottom |=> (dir_r && count_r == 16'h0001))
    else $error("dual slope did not turn at BOTTOM");
  fast_wrap_a:
    assert property ((step && cfg.cls == tmr_pkg::CLS_FAST && atTop && !countWr)
                     |=> (count_r == 16'h0000))
    else $error("fast mode did not wrap at TOP");
  bottom_load_a:
    assert property ((step && cfg.loadAt == tmr_pkg::AT_BOTTOM && atBottom)
                     |=> (cmpA_r == $past(bufA_r) && irqSt_r[tmr_pkg::IRQ_OVF]))
    else $error("BOTTOM load or overflow flag missed");
  set_wins_a:
    assert property ((ce && hitA && wrEn && paddr == tmr_pkg::OFF_IRQ_ST)
                     |=> irqSt_r[tmr_pkg::IRQ_CMPA])
    else $error("compare flag lost to a clear");
  irq_level_a:
    assert property (ce |=> (irq == |($past(irqSt_r) & $past(irqMsk_r))))
    else $error("interrupt level wrong");
endmodule // tmr_wave_ctrl
`default_nettype wire

// ---- timer16_waveform_mode_control_tb_top.sv ----
/* Self-checking bench for tmr_wave_ctrl: registers, output modes, PWM, overflow irq.
   Assumes tmr_pkg and the design files are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module timer16_waveform_mode_control_tb_top;
  logic sys_clk, rstn, ce, timerTick, psel, penable, pwrite, pready, pslverr, irq, err;
  logic waveOutA, waveOutAOeN, waveOutB, waveOutBOeN, expA, pd;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] cv;
  logic [1:0] code;
  logic [3:0] md;
  logic [3:0] modes [13] = '{4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7, 4'hD, 4'h8, 4'h9, 4'hA,
                             4'hB, 4'hE, 4'hF};
  int miscompares, testsRun, seed, i;

  tmr_wave_ctrl dut (.sys_clk(sys_clk), .rstn(rstn), .ce(ce), .timerTick(timerTick),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .waveOutA(waveOutA),
    .waveOutAOeN(waveOutAOeN), .waveOutB(waveOutB), .waveOutBOeN(waveOutBOeN));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic tally_and_finish;
    if (miscompares == 0 && testsRun > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: reg got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic got, input logic exp);
    testsRun++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: pin got %h expected %h", $time, got, exp);
    end
  endtask

  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    if (n >= 20) begin
      miscompares++;
      tally_and_finish();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk_reg(rd, exp);
  endtask

  // One cycle pulse per step; pins land one cycle after the event edge
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      timerTick <= 1'b1;
      @(posedge sys_clk);
      timerTick <= 1'b0;
    end
    repeat (3) @(posedge sys_clk);
  endtask

  initial begin
    seed = 97;
    miscompares = 0;
    testsRun = 0;
    rstn = 1'b0;
    ce = 1'b1;
    timerTick = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk_pin(waveOutAOeN, 1'b1);
    rdchk(tmr_pkg::OFF_CTRL_A, 32'h0);
    rdchk(tmr_pkg::OFF_CTRL_B, 32'h0);
    wr(tmr_pkg::OFF_CTRL_A, 32'hFF);
    rdchk(tmr_pkg::OFF_CTRL_A, 32'hF3);
    wr(tmr_pkg::OFF_CTRL_B, 32'hFF);
    rdchk(tmr_pkg::OFF_CTRL_B, 32'h18);
    apb(1'b0, 8'h40, 32'h0);
    chk_pin(err, 1'b1);
    wr(tmr_pkg::OFF_CTRL_B, 32'h0);
    wr(tmr_pkg::OFF_CTRL_A, 32'h0);
    wr(tmr_pkg::OFF_PIN, 32'h01);
    repeat (2) @(posedge sys_clk);
    chk_pin(waveOutAOeN, 1'b0);
    chk_pin(waveOutBOeN, 1'b1);
    expA = 1'b0;
    // Count written one below the match: the write blocks only the next tick
    for (i = 0; i < 6; i++) begin
      cv = 16'h1000 | 16'($random(seed) & 32'h0FFF);
      code = 2'(i % 3 + 1);
      wr(tmr_pkg::OFF_CTRL_A, {24'h0, code, 6'h00});
      wr(tmr_pkg::OFF_CMP_A, {16'h0, cv});
      wr(tmr_pkg::OFF_COUNT, {16'h0, cv - 16'h1});
      tick(2);
      expA = (code == 2'h1) ? ~expA : code[0];
      chk_pin(waveOutA, expA);
    end
    wr(tmr_pkg::OFF_IRQ_ST, 32'h7);
    wr(tmr_pkg::OFF_IRQ_MSK, 32'h1);
    wr(tmr_pkg::OFF_COUNT, 32'hFFFF);
    tick(1);
    rdchk(tmr_pkg::OFF_IRQ_ST, 32'h1);
    chk_pin(irq, 1'b1);
    wr(tmr_pkg::OFF_IRQ_ST, 32'h1);
    repeat (2) @(posedge sys_clk);
    chk_pin(irq, 1'b0);
    // Refused toggle codes, and code 00 on A where A may toggle, leave both pins on port data
    for (i = 0; i < 13; i++) begin
      md = modes[i];
      pd = 1'($random(seed));
      code = (md >= 4'h8 && md != 4'hC && md != 4'hD) ? 2'h0 : 2'h1;
      wr(tmr_pkg::OFF_PIN, {26'h0, pd, pd, 4'h3});
      wr(tmr_pkg::OFF_CTRL_B, {27'h0, md[3:2], 3'h0});
      wr(tmr_pkg::OFF_CTRL_A, {24'h0, code, 2'h1, 2'h0, md[1:0]});
      repeat (3) @(posedge sys_clk);
      chk_pin(waveOutA, pd);
      chk_pin(waveOutB, pd);
    end
    wr(tmr_pkg::OFF_PIN, 32'h03);
    wr(tmr_pkg::OFF_CTRL_B, 32'h08);
    wr(tmr_pkg::OFF_CTRL_A, 32'hA1);
    wr(tmr_pkg::OFF_CMP_A, 32'h10);
    wr(tmr_pkg::OFF_CMP_B, 32'hFF);
    wr(tmr_pkg::OFF_COUNT, 32'hFE);
    tick(2);
    chk_pin(waveOutA, 1'b1);
    tick(16'h10);
    chk_pin(waveOutA, 1'b1);
    tick(1);
    chk_pin(waveOutA, 1'b0);
    tick(16'hEE);
    wr(tmr_pkg::OFF_IRQ_ST, 32'h7);
    tick(1);
    chk_pin(waveOutB, 1'b1);
    rdchk(tmr_pkg::OFF_IRQ_ST, 32'h5);
    wr(tmr_pkg::OFF_CTRL_B, 32'h0);
    wr(tmr_pkg::OFF_CTRL_A, 32'hC1);
    wr(tmr_pkg::OFF_CMP_A, 32'hFE);
    wr(tmr_pkg::OFF_COUNT, 32'hFD);
    tick(4);
    chk_pin(waveOutA, 1'b0);
    rdchk(tmr_pkg::OFF_COUNT, 32'hFD);
    // Enable low must freeze the counter even with ticks present
    ce <= 1'b0;
    tick(2);
    ce <= 1'b1;
    rdchk(tmr_pkg::OFF_COUNT, 32'hFD);
    tick(16'hFD + 16'hFE);
    chk_pin(waveOutA, 1'b0);
    tick(1);
    chk_pin(waveOutA, 1'b1);
    // Mode 8: TOP from capture, compare buffer loads at BOTTOM
    wr(tmr_pkg::OFF_CAPT, 32'h4);
    wr(tmr_pkg::OFF_CTRL_B, 32'h10);
    wr(tmr_pkg::OFF_CTRL_A, 32'h00);
    wr(tmr_pkg::OFF_CMP_A, 32'h2);
    wr(tmr_pkg::OFF_COUNT, 32'h1);
    wr(tmr_pkg::OFF_IRQ_ST, 32'h7);
    tick(8);
    rdchk(tmr_pkg::OFF_IRQ_ST, 32'h1);
    tick(2);
    rdchk(tmr_pkg::OFF_IRQ_ST, 32'h3);
    tally_and_finish();
  end
endmodule // timer16_waveform_mode_control_tb_top
`default_nettype wire
